//--- core/scan_seq_core.sv
// Summary of operation
// (R1) one-shot output stays on for exactly one scan, then turns off
// (R2) one-shot fires on rising input change; falling variant on on-to-off change
// (R3) toggle output inverts on each off-to-on input change, holds otherwise
// (R4) drum advances only when step event is on and step timer is done
// (R5) each drum step drives its fixed pattern onto outputs 20 to 27
// (R6) one counter tops at 9999; cascaded low counter resets at 10,000 counts
// (R7) low counter holds four low digits, high counter next four
// (R8) first-scan pulse only on first scan after power-up or entering run
// (R9) first-scan latches hold flag; hold gates off critical outputs
// (R10) only operator reset pushbutton clears hold flag, releasing outputs
// (R11) internal tick pulses every 0.1 s, 10 Hz
// (R12) cumulative timer counts ticks in tenths while enabled, cascaded
// (R13) cumulative timer keeps its count while enable is off
// (R14) prescaler turns 0.1 s ticks into one pulse per second
// (R15) chained seconds, minutes, hours counters form a 24-hour clock
// (R16) operator picks hours, minutes or seconds with a 3-position selector
// (R17) each change press steps the selected time counter once
// (R18) seconds and minutes wrap 59 to 0 with carry; hours wrap 23 to 0
// (R19) all counters, latches and drum step update once per scan
`timescale 1ns/1ps
module scan_seq_core #(
  parameter int unsigned SCAN_CYC = scan_seq_pkg::SCAN_CYC,
  parameter int unsigned TICK_CYC = scan_seq_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // field inputs and pushbuttons
  input wire scan_seq_pkg::field_in_t FIELD_IN,
  input wire logic [1:0] CRIT_REQ,
  // output devices and monitors
  output logic ONESHOT_RISE,
  output logic ONESHOT_FALL,
  output logic TOGGLE_OUT,
  output logic [7:0] DRUM_OUT,
  output scan_seq_pkg::drum_step_t DRUM_STEP,
  output scan_seq_pkg::cascade_t EVENT_COUNT,
  output scan_seq_pkg::cascade_t ACCUM_TIME,
  output scan_seq_pkg::tod_t TIME_OF_DAY,
  output logic FIRST_SCAN,
  output logic HOLD_FLAG,
  output logic [1:0] CRIT_OUT,
  output logic TICK_10HZ
);
  localparam int NIN = $bits(scan_seq_pkg::field_in_t);

  // reset release synchroniser
  logic rst_a_r, rst_n_r;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end

  // pin synchronisers: a change counts once stages two and three agree
  logic [NIN-1:0] s1_r, s2_r, s3_r, flt_r, flt_nxt;
  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_sync
      always_comb begin
        flt_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : flt_r[g];
      end
    end
  endgenerate
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      flt_r <= '0;
    end else begin
      s1_r <= FIELD_IN;
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= flt_nxt;
    end
  end
  scan_seq_pkg::field_in_t fin;
  assign fin = scan_seq_pkg::field_in_t'(flt_r);

  // scan and tick dividers; a tick is held pending until the next scan sees it
  logic [31:0] scan_cnt_r, scan_cnt_nxt, tick_cnt_r, tick_cnt_nxt;
  logic scan_en, tick_en, tick_pend_r, tick_pend_nxt;
  always_comb begin
    scan_en = (scan_cnt_r == SCAN_CYC - 1);
    tick_en = (tick_cnt_r == TICK_CYC - 1); // (R11)
    scan_cnt_nxt = scan_en ? 32'h0 : scan_cnt_r + 32'h1;
    tick_cnt_nxt = tick_en ? 32'h0 : tick_cnt_r + 32'h1;
    tick_pend_nxt = tick_en | (tick_pend_r & ~scan_en);
  end
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scan_cnt_r <= 32'h0;
      tick_cnt_r <= 32'h0;
      tick_pend_r <= 1'b0;
    end else begin
      scan_cnt_r <= scan_cnt_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_pend_r <= tick_pend_nxt;
    end
  end

  function automatic scan_seq_pkg::cascade_t cascade_inc(input scan_seq_pkg::cascade_t c);
    scan_seq_pkg::cascade_t r;
    r = c;
    if (c.lo == scan_seq_pkg::DEC_MAX) begin
      r.lo = '0; // (R6)
      if (c.hi != scan_seq_pkg::DEC_MAX) begin
        r.hi = c.hi + 14'h1; // (R7)
      end
    end else begin
      r.lo = c.lo + 14'h1;
    end
    return r;
  endfunction : cascade_inc

  // scan-rate state
  scan_seq_pkg::field_in_t prev_r, prev_nxt;
  logic first_pend_r, first_pend_nxt, run_prev_r, run_prev_nxt;
  logic first_r, first_nxt, hold_r, hold_nxt, tick_r, tick_nxt;
  logic rise_r, rise_nxt, fall_r, fall_nxt, tog_r, tog_nxt;
  logic [1:0] crit_r, crit_nxt;
  logic [3:0] pre_r, pre_nxt;
  logic [scan_seq_pkg::CW-1:0] dwell_r, dwell_nxt;
  scan_seq_pkg::drum_step_t step_r, step_nxt;
  scan_seq_pkg::cascade_t cnt_r, cnt_nxt, acc_r, acc_nxt;
  scan_seq_pkg::tod_t tod_r, tod_nxt;
  logic [2:0] idx;
  logic [7:0] drum_r, drum_nxt;
  logic ev_done, sec_pulse, set_press, tick_now;
  always_comb begin
    prev_nxt = prev_r;
    first_pend_nxt = first_pend_r;
    run_prev_nxt = run_prev_r;
    first_nxt = first_r;
    hold_nxt = hold_r;
    tick_nxt = tick_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    tog_nxt = tog_r;
    crit_nxt = crit_r;
    pre_nxt = pre_r;
    dwell_nxt = dwell_r;
    step_nxt = step_r;
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    tod_nxt = tod_r;
    sec_pulse = 1'b0;
    tick_now = tick_pend_r;
    set_press = fin.set_btn & ~prev_r.set_btn;
    unique case (step_r)
      scan_seq_pkg::STEP1: idx = 3'h0;
      scan_seq_pkg::STEP2: idx = 3'h1;
      scan_seq_pkg::STEP3: idx = 3'h2;
      scan_seq_pkg::STEP4: idx = 3'h3;
      scan_seq_pkg::STEP5: idx = 3'h4;
      default: idx = 3'h5;
    endcase
    ev_done = fin.drum_event[idx] & (dwell_r >= scan_seq_pkg::DRUM_PRESET[idx]);
    drum_nxt = scan_seq_pkg::DRUM_PATTERN[idx]; // (R5)
    // entering run mode arms a new first scan
    if (fin.run_mode & ~run_prev_r) begin
      first_pend_nxt = 1'b1; // (R8)
    end
    if (scan_en) begin // (R19)
      prev_nxt = fin;
      run_prev_nxt = fin.run_mode;
      tick_nxt = tick_now;
      rise_nxt = fin.oneshot_in & ~prev_r.oneshot_in; // (R1) (R2)
      fall_nxt = ~fin.oneshot_in & prev_r.oneshot_in; // (R2)
      if (fin.toggle_in & ~prev_r.toggle_in) begin
        tog_nxt = ~tog_r; // (R3)
      end
      first_nxt = first_pend_r & fin.run_mode; // (R8)
      // hold latch: first scan sets, pushbutton clears, set wins
      if (first_nxt) begin
        first_pend_nxt = 1'b0;
        hold_nxt = 1'b1; // (R9)
      end else if (fin.oper_reset) begin
        hold_nxt = 1'b0; // (R10)
      end
      crit_nxt = CRIT_REQ & {2{~hold_nxt}}; // (R9) (R10)
      // event/time drum
      if (ev_done) begin // (R4)
        dwell_nxt = '0;
        unique case (step_r)
          scan_seq_pkg::STEP1: step_nxt = scan_seq_pkg::STEP2;
          scan_seq_pkg::STEP2: step_nxt = scan_seq_pkg::STEP3;
          scan_seq_pkg::STEP3: step_nxt = scan_seq_pkg::STEP4;
          scan_seq_pkg::STEP4: step_nxt = scan_seq_pkg::STEP5;
          scan_seq_pkg::STEP5: step_nxt = scan_seq_pkg::STEP6;
          default: step_nxt = scan_seq_pkg::STEP1;
        endcase
      end else if (tick_now && dwell_r != scan_seq_pkg::DEC_MAX) begin
        dwell_nxt = dwell_r + 14'h1;
      end
      // cascaded event counter
      if (fin.count_clr) begin
        cnt_nxt = '0;
      end else if (fin.count_in & ~prev_r.count_in) begin
        cnt_nxt = cascade_inc(cnt_r); // (R6) (R7)
      end
      // cumulative timer keeps its count while disabled
      if (fin.accum_clr) begin
        acc_nxt = '0;
      end else if (fin.accum_en && tick_now) begin
        acc_nxt = cascade_inc(acc_r); // (R12) (R13)
      end
      // time-of-day clock
      if (tick_now) begin
        sec_pulse = (pre_r == scan_seq_pkg::PRESCALE_MAX); // (R14)
        pre_nxt = sec_pulse ? 4'h0 : pre_r + 4'h1;
      end
      if (sec_pulse) begin // (R15) (R18)
        if (tod_r.sec == scan_seq_pkg::SEC_MAX) begin
          tod_nxt.sec = '0;
          if (tod_r.min == scan_seq_pkg::MIN_MAX) begin
            tod_nxt.min = '0;
            tod_nxt.hour = (tod_r.hour == scan_seq_pkg::HOUR_MAX) ? 5'h0 : tod_r.hour + 5'h1;
          end else begin
            tod_nxt.min = tod_r.min + 6'h1;
          end
        end else begin
          tod_nxt.sec = tod_r.sec + 6'h1;
        end
      end
      // manual set: one step per press, no carry
      if (set_press) begin // (R16) (R17)
        unique case (fin.set_sel)
          scan_seq_pkg::SEL_SEC: tod_nxt.sec =
            (tod_r.sec == scan_seq_pkg::SEC_MAX) ? 6'h0 : tod_r.sec + 6'h1;
          scan_seq_pkg::SEL_MIN: tod_nxt.min =
            (tod_r.min == scan_seq_pkg::MIN_MAX) ? 6'h0 : tod_r.min + 6'h1;
          scan_seq_pkg::SEL_HOUR: tod_nxt.hour =
            (tod_r.hour == scan_seq_pkg::HOUR_MAX) ? 5'h0 : tod_r.hour + 5'h1;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prev_r <= '0;
      first_pend_r <= 1'b1;
      run_prev_r <= 1'b0;
      first_r <= 1'b0;
      hold_r <= 1'b0;
      tick_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      tog_r <= 1'b0;
      crit_r <= 2'h0;
      pre_r <= 4'h0;
      dwell_r <= '0;
      step_r <= scan_seq_pkg::STEP1;
      cnt_r <= '0;
      acc_r <= '0;
      tod_r <= '0;
      drum_r <= 8'h00;
    end else begin
      prev_r <= prev_nxt;
      first_pend_r <= first_pend_nxt;
      run_prev_r <= run_prev_nxt;
      first_r <= first_nxt;
      hold_r <= hold_nxt;
      tick_r <= tick_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      tog_r <= tog_nxt;
      crit_r <= crit_nxt;
      pre_r <= pre_nxt;
      dwell_r <= dwell_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      tod_r <= tod_nxt;
      drum_r <= drum_nxt;
    end
  end

  assign ONESHOT_RISE = rise_r;
  assign ONESHOT_FALL = fall_r;
  assign TOGGLE_OUT = tog_r;
  assign DRUM_OUT = drum_r;
  assign DRUM_STEP = step_r;
  assign EVENT_COUNT = cnt_r;
  assign ACCUM_TIME = acc_r;
  assign TIME_OF_DAY = tod_r;
  assign FIRST_SCAN = first_r;
  assign HOLD_FLAG = hold_r;
  assign CRIT_OUT = crit_r;
  assign TICK_10HZ = tick_r;
endmodule : scan_seq_core

//--- core/scan_seq_pkg.sv
package scan_seq_pkg;
  // clock and derived timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SCAN_PERIOD_US = 1000;
  localparam int unsigned SCAN_CYC = CLK_HZ / 1_000_000 * SCAN_PERIOD_US;
  localparam int unsigned TICK_PERIOD_MS = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_PERIOD_MS;
  // decimal counter limits
  localparam int CW = 14;
  localparam logic [CW-1:0] DEC_MAX = 14'h270F;
  localparam logic [3:0] PRESCALE_MAX = 4'h9;
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  // time-set selector codes
  localparam logic [1:0] SEL_SEC = 2'h1;
  localparam logic [1:0] SEL_MIN = 2'h2;
  localparam logic [1:0] SEL_HOUR = 2'h3;
  // drum step table: bit 0 is output 20, bit 7 is output 27
  localparam int DRUM_STEPS = 6;
  localparam logic [DRUM_STEPS-1:0][7:0] DRUM_PATTERN = {
    8'h00, 8'hFD, 8'h47, 8'h6E, 8'h90, 8'h76};
  // step dwell presets in tenths of a second
  localparam logic [DRUM_STEPS-1:0][CW-1:0] DRUM_PRESET = {
    14'h000A, 14'h000A, 14'h000A, 14'h000A, 14'h000A, 14'h000A};

  typedef enum logic [5:0] {
    STEP1 = 6'h01, STEP2 = 6'h02, STEP3 = 6'h04,
    STEP4 = 6'h08, STEP5 = 6'h10, STEP6 = 6'h20
  } drum_step_t;

  typedef struct packed {
    logic run_mode;
    logic oper_reset;
    logic oneshot_in;
    logic toggle_in;
    logic count_in;
    logic count_clr;
    logic accum_en;
    logic accum_clr;
    logic set_btn;
    logic [1:0] set_sel;
    logic [DRUM_STEPS-1:0] drum_event;
  } field_in_t;

  typedef struct packed {
    logic [CW-1:0] hi;
    logic [CW-1:0] lo;
  } cascade_t;

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } tod_t;
endpackage : scan_seq_pkg

//--- bench/field_side.sv
`timescale 1ns/1ps
module field_side #(
  parameter int SCAN_CYC = 20
) (
  // clock
  input wire logic SYS_CLK,
  // field wiring toward the controller
  output scan_seq_pkg::field_in_t FIELD,
  output logic [1:0] CRIT
);
  initial begin
    FIELD = '0;
    CRIT = 2'h0;
  end
  // levels only change on the falling edge
  task automatic put(input scan_seq_pkg::field_in_t f, input logic [1:0] c);
    @(negedge SYS_CLK);
    FIELD <= f;
    CRIT <= c;
  endtask : put
  // selector set, then n presses; each press and release stands two scans
  task automatic press(input logic [1:0] sel, input int n);
    scan_seq_pkg::field_in_t f;
    f = FIELD;
    f.set_sel = sel;
    for (int i = 0; i < n; i++) begin
      f.set_btn = 1'b1;
      put(f, CRIT);
      repeat (2 * SCAN_CYC) @(negedge SYS_CLK);
      f.set_btn = 1'b0;
      put(f, CRIT);
      repeat (2 * SCAN_CYC) @(negedge SYS_CLK);
    end
  endtask : press
endmodule : field_side

//--- bench/scan_seq_chk.sv
`timescale 1ns/1ps
module scan_seq_chk #(
  parameter int unsigned SCAN_CYC = scan_seq_pkg::SCAN_CYC,
  parameter int unsigned TICK_CYC = scan_seq_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // watched ports
  input wire scan_seq_pkg::field_in_t FIELD_IN,
  input wire logic [1:0] CRIT_OUT,
  input wire logic ONESHOT_RISE,
  input wire logic ONESHOT_FALL,
  input wire logic TOGGLE_OUT,
  input wire scan_seq_pkg::drum_step_t DRUM_STEP,
  input wire scan_seq_pkg::cascade_t EVENT_COUNT,
  input wire scan_seq_pkg::tod_t TIME_OF_DAY,
  input wire logic FIRST_SCAN,
  input wire logic HOLD_FLAG,
  input wire logic TICK_10HZ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  int unsigned len_r, len_nxt, gap_r, gap_nxt;
  logic tk_r, seen_r, seen_nxt;
  always_comb begin
    len_nxt = ONESHOT_RISE ? len_r + 1 : 0;
    gap_nxt = (TICK_10HZ && !tk_r) ? 1 : gap_r + 1;
    seen_nxt = seen_r || (TICK_10HZ && !tk_r);
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      len_r <= 0;
      gap_r <= 0;
      tk_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      len_r <= len_nxt;
      gap_r <= gap_nxt;
      tk_r <= TICK_10HZ;
      seen_r <= seen_nxt;
    end
  end
  sequence s_pulse_end;
    $fell(ONESHOT_RISE);
  endsequence
  sequence s_tick_again;
    TICK_10HZ && !tk_r && seen_r;
  endsequence
  a_rise_one_scan: assert property (s_pulse_end |-> len_r == SCAN_CYC)
    else $error("one-shot width is not one scan");
  a_rise_on_input: assert property ($rose(ONESHOT_RISE) |-> FIELD_IN.oneshot_in)
    else $error("rising one-shot without input");
  a_fall_on_input: assert property ($rose(ONESHOT_FALL) |-> !FIELD_IN.oneshot_in)
    else $error("falling one-shot with input on");
  a_toggle_on_rise: assert property ($changed(TOGGLE_OUT) |-> FIELD_IN.toggle_in)
    else $error("toggle changed without input");
  a_drum_needs_event: assert property ($changed(DRUM_STEP) |->
    |($past(DRUM_STEP) & FIELD_IN.drum_event))
    else $error("drum advanced without its event");
  a_drum_one_hot: assert property ($onehot(DRUM_STEP))
    else $error("drum step not one-hot");
  a_count_limit: assert property (EVENT_COUNT.lo <= scan_seq_pkg::DEC_MAX
    && EVENT_COUNT.hi <= scan_seq_pkg::DEC_MAX)
    else $error("event counter above limit");
  a_first_in_run: assert property ($rose(FIRST_SCAN) |-> FIELD_IN.run_mode)
    else $error("first scan outside run");
  a_hold_gates_crit: assert property (HOLD_FLAG |-> CRIT_OUT == 2'h0)
    else $error("critical output on during hold");
  a_hold_set_first: assert property ($rose(HOLD_FLAG) |->
    FIRST_SCAN || $past(FIRST_SCAN))
    else $error("hold set without first scan");
  a_hold_clear_btn: assert property ($fell(HOLD_FLAG) |-> FIELD_IN.oper_reset)
    else $error("hold cleared without reset button");
  a_tick_period: assert property (s_tick_again |-> gap_r == TICK_CYC)
    else $error("tick spacing wrong");
  a_tod_range: assert property (TIME_OF_DAY.sec <= scan_seq_pkg::SEC_MAX
    && TIME_OF_DAY.min <= scan_seq_pkg::MIN_MAX
    && TIME_OF_DAY.hour <= scan_seq_pkg::HOUR_MAX)
    else $error("time of day out of range");
endmodule : scan_seq_chk
bind scan_seq_core scan_seq_chk #(.SCAN_CYC(SCAN_CYC), .TICK_CYC(TICK_CYC)) scan_seq_chk_inst (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .FIELD_IN(FIELD_IN), .CRIT_OUT(CRIT_OUT),
  .ONESHOT_RISE(ONESHOT_RISE), .ONESHOT_FALL(ONESHOT_FALL), .TOGGLE_OUT(TOGGLE_OUT),
  .DRUM_STEP(DRUM_STEP), .EVENT_COUNT(EVENT_COUNT), .TIME_OF_DAY(TIME_OF_DAY),
  .FIRST_SCAN(FIRST_SCAN), .HOLD_FLAG(HOLD_FLAG), .TICK_10HZ(TICK_10HZ));

//--- bench/scan_seq_core_tb.sv
`timescale 1ns/1ps
module scan_seq_core_tb;
  localparam int SC = 20;
  localparam int TC = 100;
  localparam logic [7:0] PAT [6] = '{8'h76, 8'h90, 8'h6E, 8'h47, 8'hFD, 8'h00};
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  scan_seq_pkg::field_in_t FIELD_IN, v;
  logic [1:0] CRIT_REQ, CRIT_OUT;
  logic ONESHOT_RISE, ONESHOT_FALL, TOGGLE_OUT, FIRST_SCAN, HOLD_FLAG, TICK_10HZ;
  logic [7:0] DRUM_OUT;
  scan_seq_pkg::drum_step_t DRUM_STEP, st;
  scan_seq_pkg::cascade_t EVENT_COUNT, ACCUM_TIME;
  scan_seq_pkg::tod_t TIME_OF_DAY;
  int miscompares = 0;
  int samples_checked = 0;
  int n_fs = 0, n_or = 0, n_of = 0, n;
  logic p_fs = 1'b0, p_or = 1'b0, p_of = 1'b0;
  logic [5:0] s0;
  field_side #(.SCAN_CYC(SC)) field_side_inst (.SYS_CLK(SYS_CLK), .FIELD(FIELD_IN),
    .CRIT(CRIT_REQ));
  scan_seq_core #(.SCAN_CYC(SC), .TICK_CYC(TC)) scan_seq_core_inst (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .FIELD_IN(FIELD_IN), .CRIT_REQ(CRIT_REQ),
    .ONESHOT_RISE(ONESHOT_RISE), .ONESHOT_FALL(ONESHOT_FALL), .TOGGLE_OUT(TOGGLE_OUT),
    .DRUM_OUT(DRUM_OUT), .DRUM_STEP(DRUM_STEP), .EVENT_COUNT(EVENT_COUNT),
    .ACCUM_TIME(ACCUM_TIME), .TIME_OF_DAY(TIME_OF_DAY), .FIRST_SCAN(FIRST_SCAN),
    .HOLD_FLAG(HOLD_FLAG), .CRIT_OUT(CRIT_OUT), .TICK_10HZ(TICK_10HZ));
  initial begin
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  // pulse counters for one-scan outputs
  always @(negedge SYS_CLK) begin
    n_fs += (FIRST_SCAN === 1'b1 && !p_fs);
    n_or += (ONESHOT_RISE === 1'b1 && !p_or);
    n_of += (ONESHOT_FALL === 1'b1 && !p_of);
    p_fs = FIRST_SCAN;
    p_or = ONESHOT_RISE;
    p_of = ONESHOT_FALL;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge SYS_CLK);
  endtask : cyc
  task automatic drv(input int scans);
    field_side_inst.put(v, 2'h3);
    cyc(scans * SC);
  endtask : drv
  task automatic final_report();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    cyc(60000);
    miscompares++;
    final_report();
  end
  initial begin
    v = '0;
    cyc(4);
    RST_N = 1'b1;
    cyc(5);
    chk(DRUM_STEP, scan_seq_pkg::STEP1);
    chk(HOLD_FLAG, 1'b0);
    v.run_mode = 1'b1;
    drv(3);
    chk(n_fs, 1);
    chk(HOLD_FLAG, 1'b1);
    chk(CRIT_OUT, 2'h0);
    v.run_mode = 1'b0;
    drv(3);
    v.run_mode = 1'b1;
    drv(3);
    chk(n_fs, 2);
    v.oper_reset = 1'b1;
    drv(3);
    v.oper_reset = 1'b0;
    drv(3);
    chk(HOLD_FLAG, 1'b0);
    chk(CRIT_OUT, 2'h3);
    for (int i = 0; i < 3; i++) begin
      {v.oneshot_in, v.toggle_in, v.count_in} = 3'h7;
      drv(3);
      chk(TOGGLE_OUT, !i[0]);
      {v.oneshot_in, v.toggle_in, v.count_in} = 3'h0;
      drv(3);
      chk(TOGGLE_OUT, !i[0]);
    end
    chk(n_or, 3);
    chk(n_of, 3);
    chk(EVENT_COUNT, 3);
    v.count_clr = 1'b1;
    drv(2);
    v.count_clr = 1'b0;
    drv(2);
    chk(EVENT_COUNT, 0);
    // align enable windows between ticks so each window holds four
    @(posedge TICK_10HZ);
    cyc(1);
    v.accum_en = 1'b1;
    drv(20);
    v.accum_en = 1'b0;
    drv(20);
    chk(ACCUM_TIME, 4);
    v.accum_en = 1'b1;
    drv(20);
    v.accum_en = 1'b0;
    drv(1);
    chk(ACCUM_TIME, 8);
    v.accum_clr = 1'b1;
    drv(2);
    v.accum_clr = 1'b0;
    drv(1);
    chk(ACCUM_TIME, 0);
    field_side_inst.press(scan_seq_pkg::SEL_MIN, 59);
    chk(TIME_OF_DAY.min, 59);
    field_side_inst.press(2'h0, 2);
    chk(TIME_OF_DAY.min, 59);
    for (int i = 0; i < 60 && TIME_OF_DAY.sec < 50; i++) begin
      field_side_inst.press(scan_seq_pkg::SEL_SEC, 1);
    end
    for (n = 0; n < 12000 && TIME_OF_DAY.min !== 6'h00; n++) cyc(1);
    chk(TIME_OF_DAY, {5'h01, 6'h00, 6'h00});
    s0 = TIME_OF_DAY.sec;
    for (n = 0; n < 1500 && TIME_OF_DAY.sec === s0; n++) cyc(1);
    chk(n, 10 * TC);
    field_side_inst.press(scan_seq_pkg::SEL_HOUR, 23);
    chk(TIME_OF_DAY.hour, 0);
    chk(DRUM_STEP, scan_seq_pkg::STEP1);
    chk(DRUM_OUT, PAT[0]);
    for (int s = 0; s < 6; s++) begin
      st = DRUM_STEP;
      v.drum_event = 6'h01 << s;
      field_side_inst.put(v, 2'h3);
      for (n = 0; n < 1500 && DRUM_STEP === st; n++) cyc(1);
      chk(s == 0 || n >= 9 * TC, 1'b1);
      chk(DRUM_STEP, 6'h01 << ((s + 1) % 6));
      cyc(1);
      chk(DRUM_OUT, PAT[(s + 1) % 6]);
    end
    final_report();
  end
endmodule : scan_seq_core_tb
